// *** verilog/uart_line_modem_status_regs.sv ***
`timescale 1ns/1ps
`include "uart_regs_consts.svh"

// synchronous FIFO, optionally limited to one entry
module uart_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // control
  input  wire logic                 clear,
  input  wire logic                 oneDeep,
  // fill side
  input  wire logic                 inValid,
  input  wire logic [W-1:0]         inData,
  output      logic                 inReady,
  // drain side
  output      logic                 outValid,
  output      logic [W-1:0]         outData,
  input  wire logic                 outReady,
  output      logic [$clog2(D+1)-1:0] count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic          push;
  logic          pop;

  // handshakes
  assign inReady  = oneDeep ? (count == '0) : (count != D[$clog2(D+1)-1:0]);
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // pointers and fill count
  always_ff @(posedge clk_sys) begin
    if (!resetn || clear) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count   <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  // storage
  always_ff @(posedge clk_sys) begin
    if (push) mem[wrPtr_q] <= inData;
  end
endmodule

module uart_line_modem_status_regs (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // host register port
  input  wire logic [2:0] addr,
  input  wire logic       chipSel_n,
  input  wire logic       rdStb_n,
  input  wire logic       wrStb_n,
  input  wire logic [7:0] wrData,
  output      logic [7:0] rdData,
  output      logic       rdDataOe_n,
  // serial line
  input  wire logic       serialIn,
  output      logic       serialOut,
  // modem handshake
  input  wire logic       clrToSend_n,
  input  wire logic       dataSetReady_n,
  input  wire logic       bellIndicateIn_n,
  input  wire logic       carrierDetectIn_n,
  output      logic       termReady_n,
  output      logic       reqToSend_n,
  // interrupt and buffered reset
  output      logic       irqOut,
  output      logic       irqOe_n,
  output      logic       rstOut
);
  logic [7:0] irqEn_q, lineFmt_q, modemCtl_q, scratch_q, featReg_q;
  logic [15:0] div_q;
  logic [15:0] baudCnt_q;
  logic fifoEn_q;
  logic [1:0] rxTrig_q;
  logic rdPrev_q, wrPrev_q;
  logic rdEvt, wrEvt, dlab, loop, enh, pdown, tick;
  logic [7:0] rdMux;
  logic [2:0] iid;
  logic anyIrq;

  // character length mask
  function automatic logic [7:0] dataMask(input logic [1:0] len);
    return 8'hFF >> (2'd3 - len);
  endfunction

  // parity bit for a character under the given format
  function automatic logic parBit(input logic [7:0] d, input logic [7:0] fmt);
    logic [7:0] m;
    m = d & dataMask(fmt[1:0]);
    if (fmt[`FMT_STICK]) return ~fmt[`FMT_EVEN];
    return fmt[`FMT_EVEN] ? ^m : ~^m;
  endfunction

  // one access per strobe falling edge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdPrev_q <= 1'b1;
      wrPrev_q <= 1'b1;
    end else begin
      rdPrev_q <= chipSel_n | rdStb_n;
      wrPrev_q <= chipSel_n | wrStb_n;
    end
  end
  assign rdEvt = !(chipSel_n | rdStb_n) && rdPrev_q;
  assign wrEvt = !(chipSel_n | wrStb_n) && wrPrev_q;
  assign dlab  = lineFmt_q[`FMT_DLAB];
  assign loop  = modemCtl_q[`MC_LOOP];
  assign enh   = irqEn_q[`IE_ENH];
  assign pdown = enh && modemCtl_q[`MC_PDOWN];

  logic wrData0, wrIe, wrFc, wrFeat;
  assign wrData0 = wrEvt && addr == `OFS_DATA && !dlab;
  assign wrIe    = wrEvt && addr == `OFS_IRQ_EN && !dlab;
  assign wrFc    = wrEvt && addr == `OFS_IRQ_STAT && !dlab;
  assign wrFeat  = wrEvt && addr == `OFS_IRQ_STAT && dlab;

  // control registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      irqEn_q    <= `RST_BYTE;
      lineFmt_q  <= `RST_BYTE;
      modemCtl_q <= `RST_BYTE;
      scratch_q  <= `RST_BYTE;
      featReg_q  <= `RST_BYTE;
      div_q      <= `RST_DIV;
      fifoEn_q   <= 1'b0;
      rxTrig_q   <= 2'b00;
    end else if (wrEvt) begin
      case (addr)
        `OFS_DATA:      if (dlab) div_q[7:0] <= wrData;
        `OFS_IRQ_EN:    if (dlab) div_q[15:8] <= wrData;
                        else irqEn_q <= wrData & 8'h2F;
        `OFS_IRQ_STAT:  if (dlab) featReg_q <= wrData;
                        else begin
                          fifoEn_q <= wrData[`FC_EN];
                          if (wrData[`FC_EN]) rxTrig_q <= wrData[7:6];
                        end
        `OFS_LINE_FMT:  lineFmt_q <= wrData;
        `OFS_MODEM_CTL: modemCtl_q <= wrData & 8'h9F;
        `OFS_SCRATCH:   scratch_q <= wrData;
        default:        ;
      endcase
    end
  end

  // baud generator, 16 ticks per bit, halted in power down
  always_ff @(posedge clk_sys) begin
    if (!resetn) baudCnt_q <= `RST_DIV;
    else if (!pdown) baudCnt_q <= (baudCnt_q <= 16'h0001) ? div_q : baudCnt_q - 16'h0001;
  end
  assign tick = !pdown && baudCnt_q <= 16'h0001;

  // fifos
  uart_regs_pkg::rxWord_t rxHead, rxWordNew;
  logic txInReady, txValid, txPop, rxInReady, rxValid, rxPop, rxPush;
  logic [7:0] txData;
  logic [4:0] txCount, rxCount;
  logic fcClrRx, fcClrTx;
  assign fcClrRx = wrFc && (wrData[`FC_RXCLR] || wrData[`FC_EN] != fifoEn_q);
  assign fcClrTx = wrFc && (wrData[`FC_TXCLR] || wrData[`FC_EN] != fifoEn_q);
  assign rxPop   = rdEvt && addr == `OFS_DATA && !dlab;

  uart_fifo #(.W(8), .D(16)) txFifo (
    .clk_sys(clk_sys), .resetn(resetn), .clear(fcClrTx), .oneDeep(!fifoEn_q),
    .inValid(wrData0), .inData(wrData), .inReady(txInReady),
    .outValid(txValid), .outData(txData), .outReady(txPop), .count(txCount)
  );
  uart_fifo #(.W(11), .D(16)) rxFifo (
    .clk_sys(clk_sys), .resetn(resetn), .clear(fcClrRx), .oneDeep(!fifoEn_q),
    .inValid(rxPush), .inData(rxWordNew), .inReady(rxInReady),
    .outValid(rxValid), .outData(rxHead), .outReady(rxPop), .count(rxCount)
  );

  // transmitter
  uart_regs_pkg::txState_t txSt_q;
  logic [5:0] txTk_q;
  logic [2:0] txIdx_q;
  logic [7:0] txSh_q;
  logic txLine;
  logic [5:0] stopEnd;
  logic [2:0] lastIdx;
  assign lastIdx = 3'd4 + {1'b0, lineFmt_q[1:0]};
  assign stopEnd = !lineFmt_q[2] ? `TK_STOP1 :
                   (lineFmt_q[1:0] == 2'b00) ? `TK_STOP15 : `TK_STOP2;
  assign txPop   = (txSt_q == uart_regs_pkg::TX_IDLE) && txValid;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      txSt_q  <= uart_regs_pkg::TX_IDLE;
      txTk_q  <= 6'h00;
      txIdx_q <= 3'h0;
      txSh_q  <= 8'h00;
    end else if (txPop) begin
      txSt_q <= uart_regs_pkg::TX_START;
      txSh_q <= txData;
      txTk_q <= 6'h00;
    end else if (tick && txSt_q != uart_regs_pkg::TX_IDLE) begin
      txTk_q <= txTk_q + 6'h01;
      case (txSt_q)
        uart_regs_pkg::TX_START: if (txTk_q == `TK_BIT_END) begin
          txSt_q <= uart_regs_pkg::TX_DATA;
          txIdx_q <= 3'h0;
          txTk_q <= 6'h00;
        end
        uart_regs_pkg::TX_DATA: if (txTk_q == `TK_BIT_END) begin
          txTk_q <= 6'h00;
          txIdx_q <= txIdx_q + 3'h1;
          if (txIdx_q == lastIdx)
            txSt_q <= lineFmt_q[`FMT_PAR_EN] ? uart_regs_pkg::TX_PAR
                                             : uart_regs_pkg::TX_STOP;
        end
        uart_regs_pkg::TX_PAR: if (txTk_q == `TK_BIT_END) begin
          txSt_q <= uart_regs_pkg::TX_STOP;
          txTk_q <= 6'h00;
        end
        uart_regs_pkg::TX_STOP: if (txTk_q == stopEnd) txSt_q <= uart_regs_pkg::TX_IDLE;
        default: txSt_q <= uart_regs_pkg::TX_IDLE;
      endcase
    end
  end
  always_comb begin
    case (txSt_q)
      uart_regs_pkg::TX_START: txLine = 1'b0;
      uart_regs_pkg::TX_DATA:  txLine = txSh_q[txIdx_q];
      uart_regs_pkg::TX_PAR:   txLine = parBit(txSh_q, lineFmt_q);
      default:                 txLine = 1'b1;
    endcase
  end

  // serial pins; break forces low, loopback parks the pin at mark
  logic txInt;
  assign txInt = txLine && !lineFmt_q[`FMT_BREAK];
  always_ff @(posedge clk_sys) begin
    if (!resetn) serialOut <= 1'b1;
    else serialOut <= loop ? 1'b1 : txInt;
  end

  // receiver
  uart_regs_pkg::rxState_t rxSt_q;
  logic [5:0] rxTk_q;
  logic [2:0] rxIdx_q;
  logic [7:0] rxSh_q;
  logic rxPar_q, rxIn, rxDone, overrun_q, fifoErr_q;
  logic [9:0] tmo_q;
  assign rxIn = loop ? txInt : serialIn;
  assign rxDone = tick && rxSt_q == uart_regs_pkg::RX_STOP && rxTk_q == `TK_BIT_END;
  always_comb begin
    rxWordNew.data = rxSh_q;
    rxWordNew.frm  = !rxIn;
    rxWordNew.par  = lineFmt_q[`FMT_PAR_EN] && (rxPar_q != parBit(rxSh_q, lineFmt_q));
    rxWordNew.brk  = !rxIn && rxSh_q == 8'h00 &&
                     !(lineFmt_q[`FMT_PAR_EN] && rxPar_q);
  end
  assign rxPush = rxDone && rxInReady;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rxSt_q  <= uart_regs_pkg::RX_IDLE;
      rxTk_q  <= 6'h00;
      rxIdx_q <= 3'h0;
      rxSh_q  <= 8'h00;
      rxPar_q <= 1'b0;
    end else if (rxSt_q == uart_regs_pkg::RX_IDLE) begin
      if (!rxIn) begin
        rxSt_q <= uart_regs_pkg::RX_START;
        rxTk_q <= 6'h00;
      end
    end else if (rxSt_q == uart_regs_pkg::RX_BRKWAIT) begin
      if (rxIn) rxSt_q <= uart_regs_pkg::RX_IDLE;
    end else if (tick) begin
      rxTk_q <= rxTk_q + 6'h01;
      case (rxSt_q)
        uart_regs_pkg::RX_START: if (rxTk_q == `TK_HALF) begin
          rxSt_q  <= rxIn ? uart_regs_pkg::RX_IDLE : uart_regs_pkg::RX_DATA;
          rxTk_q  <= 6'h00;
          rxIdx_q <= 3'h0;
          rxSh_q  <= 8'h00;
        end
        uart_regs_pkg::RX_DATA: if (rxTk_q == `TK_BIT_END) begin
          rxTk_q <= 6'h00;
          rxSh_q[rxIdx_q] <= rxIn;
          rxIdx_q <= rxIdx_q + 3'h1;
          if (rxIdx_q == lastIdx)
            rxSt_q <= lineFmt_q[`FMT_PAR_EN] ? uart_regs_pkg::RX_PAR
                                             : uart_regs_pkg::RX_STOP;
        end
        uart_regs_pkg::RX_PAR: if (rxTk_q == `TK_BIT_END) begin
          rxTk_q <= 6'h00;
          rxPar_q <= rxIn;
          rxSt_q <= uart_regs_pkg::RX_STOP;
        end
        uart_regs_pkg::RX_STOP: if (rxTk_q == `TK_BIT_END) begin
          rxSt_q <= rxWordNew.brk ? uart_regs_pkg::RX_BRKWAIT : uart_regs_pkg::RX_IDLE;
          rxPar_q <= 1'b0;
        end
        default: rxSt_q <= uart_regs_pkg::RX_IDLE;
      endcase
    end
  end

  // overrun and FIFO error flags: set beats the read clear
  logic rdLineSt;
  assign rdLineSt = rdEvt && addr == `OFS_LINE_STAT;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      overrun_q <= 1'b0;
      fifoErr_q <= 1'b0;
    end else begin
      overrun_q <= (rxDone && !rxInReady) || (overrun_q && !rdLineSt);
      fifoErr_q <= (rxPush && fifoEn_q && (rxWordNew.par || rxWordNew.frm || rxWordNew.brk))
                   || (fifoErr_q && !rdLineSt);
    end
  end

  // receive timeout: idle ticks with data waiting
  always_ff @(posedge clk_sys) begin
    if (!resetn || rxPush || rxPop || !rxValid) tmo_q <= 10'h000;
    else if (tick && tmo_q != `RX_TMO_TICKS) tmo_q <= tmo_q + 10'h001;
  end

  // line status
  logic thre, temt;
  logic [7:0] lineSt;
  assign thre = !txValid;
  assign temt = thre && txSt_q == uart_regs_pkg::TX_IDLE;
  assign lineSt = {fifoErr_q, temt, thre, rxValid && rxHead.brk,
                   rxValid && rxHead.frm, rxValid && rxHead.par,
                   overrun_q, rxValid};

  // modem status with loopback routing
  logic [3:0] mdm, mdmPrev_q, delta_q;
  logic mdmArm_q, rdModem;
  assign rdModem = rdEvt && addr == `OFS_MODEM_STA;
  assign mdm = loop ? {modemCtl_q[3], modemCtl_q[2], modemCtl_q[0], modemCtl_q[1]}
                    : {!carrierDetectIn_n, !bellIndicateIn_n, !dataSetReady_n, !clrToSend_n};
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mdmPrev_q <= 4'h0;
      delta_q   <= 4'h0;
      mdmArm_q  <= 1'b0;
    end else begin
      mdmArm_q  <= 1'b1;
      mdmPrev_q <= mdm;
      delta_q   <= (mdmArm_q ? {mdm[3] ^ mdmPrev_q[3], !mdm[2] && mdmPrev_q[2],
                                mdm[1:0] ^ mdmPrev_q[1:0]} : 4'h0)
                   | (rdModem ? 4'h0 : delta_q);
    end
  end

  // interrupt sources in priority order
  logic threPend_q, rlsI, rdaI, tmoI, thrI, msiI, rdIrqSt;
  logic [4:0] trigLvl;
  always_comb begin
    case (rxTrig_q)
      2'b00:   trigLvl = 5'd1;
      2'b01:   trigLvl = 5'd4;
      2'b10:   trigLvl = 5'd8;
      default: trigLvl = 5'd14;
    endcase
  end
  assign rlsI = irqEn_q[`IE_RLS] && |lineSt[4:1];
  assign rdaI = irqEn_q[`IE_RDA] && (fifoEn_q ? rxCount >= trigLvl : rxValid);
  assign tmoI = irqEn_q[`IE_RDA] && fifoEn_q && tmo_q == `RX_TMO_TICKS;
  assign thrI = irqEn_q[`IE_THRE] && threPend_q;
  assign msiI = irqEn_q[`IE_MSI] && |delta_q;
  assign anyIrq = rlsI || rdaI || tmoI || thrI || msiI;
  always_comb begin
    if (rlsI) iid = `IID_RLS;
    else if (rdaI) iid = `IID_RDA;
    else if (tmoI) iid = `IID_TMO;
    else if (thrI) iid = `IID_THRE;
    else iid = `IID_MSI;
  end
  assign rdIrqSt = rdEvt && addr == `OFS_IRQ_STAT && !dlab;

  // holding-empty interrupt pending; read of status clears it when current
  logic threPrev_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      threPrev_q <= 1'b1;
      threPend_q <= 1'b0;
    end else begin
      threPrev_q <= thre;
      threPend_q <= (thre && !threPrev_q) ||
                    (wrIe && wrData[`IE_THRE] && !irqEn_q[`IE_THRE] && thre) ||
                    (threPend_q && !wrData0 &&
                     !(rdIrqSt && !rlsI && !rdaI && !tmoI && thrI));
    end
  end

  // interrupt status byte
  logic [7:0] irqSt;
  assign irqSt = {{2{fifoEn_q}},
                  enh && rxValid,
                  enh && txInReady,
                  anyIrq ? iid : 3'h0, !anyIrq};

  // read mux
  always_comb begin
    case (addr)
      `OFS_DATA:      rdMux = dlab ? div_q[7:0] : rxHead.data;
      `OFS_IRQ_EN:    rdMux = dlab ? div_q[15:8] : irqEn_q;
      `OFS_IRQ_STAT:  rdMux = dlab ? featReg_q : irqSt;
      `OFS_LINE_FMT:  rdMux = lineFmt_q;
      `OFS_MODEM_CTL: rdMux = modemCtl_q;
      `OFS_LINE_STAT: rdMux = lineSt;
      `OFS_MODEM_STA: rdMux = {mdm, delta_q};
      default:        rdMux = scratch_q;
    endcase
  end

  // read data captured on the strobe edge, driven from the next cycle while strobe held
  always_ff @(posedge clk_sys) begin
    if (!resetn) rdData <= `RST_BYTE;
    else if (rdEvt) rdData <= rdMux;
  end
  assign rdDataOe_n = chipSel_n | rdStb_n | rdEvt;

  // modem and interrupt outputs
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      termReady_n <= 1'b1;
      reqToSend_n <= 1'b1;
      irqOut      <= 1'b0;
      irqOe_n     <= 1'b1;
    end else begin
      termReady_n <= loop || !modemCtl_q[`MC_DTR];
      reqToSend_n <= loop || !modemCtl_q[`MC_RTS];
      irqOut      <= anyIrq;
      irqOe_n     <= loop || !modemCtl_q[`MC_IRQ_DRV];
    end
  end

  // buffered reset: hardware reset, plus soft reset in enhanced mode
  assign rstOut = !resetn || (enh && modemCtl_q[`MC_SOFTRST]);
endmodule

// *** verilog/uart_regs_consts.svh ***
`ifndef UART_REGS_CONSTS_SVH
`define UART_REGS_CONSTS_SVH
// Operation
// - status bit0 low while enabled interrupt pending
// - bits 1-3 code highest pending source
// - enhanced mode bit4 shows transmitter not full
// - enhanced mode bit5 shows receiver holds data
// - bits 6-7 read ones when FIFOs enabled
// - format bits 1:0 select 5-8 data bits
// - format bit2 selects 1, 1.5 or 2 stops
// - format bit3 enables parity, bit4 even/odd
// - format bit5 forces parity to inverse bit4
// - format bit6 holds serial output low
// - format bit7 maps divisor and feature register
// - control bits 0,1 drive ready pins inverted
// - reset output ORs soft reset when enhanced
// - control bit3 enables interrupt pin drive
// - loopback isolates pins, routes modem from control
// - loopback ring and carrier from bits 2,3 uninverted
// - control bit7 stops baud generator when enhanced
// - line status bit0 shows received data waiting
// - full receive FIFO sets overrun, drops character
// - parity and framing flags follow head character
// - full-frame low sets break, one character loaded
// - holding-empty sets on FIFO empty, clears on write
// - transmitter-empty needs FIFO and shifter empty
// - source priority fixed, status read clears holding-empty when current
// - enhanced features only with enable bit5 set
`define OFS_DATA      3'h0
`define OFS_IRQ_EN    3'h1
`define OFS_IRQ_STAT  3'h2
`define OFS_LINE_FMT  3'h3
`define OFS_MODEM_CTL 3'h4
`define OFS_LINE_STAT 3'h5
`define OFS_MODEM_STA 3'h6
`define OFS_SCRATCH   3'h7
`define RST_BYTE      8'h00
`define RST_DIV       16'h0001
`define FMT_PAR_EN    3
`define FMT_EVEN      4
`define FMT_STICK     5
`define FMT_BREAK     6
`define FMT_DLAB      7
`define MC_DTR        0
`define MC_RTS        1
`define MC_SOFTRST    2
`define MC_IRQ_DRV    3
`define MC_LOOP       4
`define MC_PDOWN      7
`define IE_RDA        0
`define IE_THRE       1
`define IE_RLS        2
`define IE_MSI        3
`define IE_ENH        5
`define FC_EN         0
`define FC_RXCLR      1
`define FC_TXCLR      2
`define TK_BIT_END    6'h0F
`define TK_HALF       6'h07
`define TK_STOP1      6'h0F
`define TK_STOP15     6'h17
`define TK_STOP2      6'h1F
`define RX_TMO_TICKS  10'h280
`define IID_RLS       3'h3
`define IID_RDA       3'h2
`define IID_TMO       3'h6
`define IID_THRE      3'h1
`define IID_MSI       3'h0
`endif

// *** verilog/uart_regs_pkg.sv ***
package uart_regs_pkg;
  // one received character with its error flags
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } rxWord_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} txState_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRKWAIT} rxState_t;
endpackage

// *** dv/uart_regs_asserts.sv ***
`timescale 1ns/1ps
module uart_regs_checker (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // host register port
  input wire logic [2:0] addr,
  input wire logic       chipSel_n,
  input wire logic       rdStb_n,
  input wire logic       wrStb_n,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  // pins
  input wire logic       serialOut,
  input wire logic       termReady_n,
  input wire logic       reqToSend_n,
  input wire logic       irqOe_n,
  input wire logic       rstOut
);
  logic [7:0] fmt_q;
  logic [7:0] mc_q;
  logic [7:0] ie_q;
  logic       acc_q;
  logic       rdIsr_q;
  logic       rdLsr_q;
  logic       wrTake;
  logic       rdTake;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // first cycle of a strobe is the taken access
  assign wrTake = !chipSel_n && !wrStb_n && !acc_q;
  assign rdTake = !chipSel_n && !rdStb_n && !acc_q;
  // shadow copies of the written control bytes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      acc_q   <= 1'b0;
      fmt_q   <= 8'h00;
      mc_q    <= 8'h00;
      ie_q    <= 8'h00;
      rdIsr_q <= 1'b0;
      rdLsr_q <= 1'b0;
    end else begin
      acc_q   <= !chipSel_n && (!rdStb_n || !wrStb_n);
      rdIsr_q <= rdTake && addr == 3'h2 && !fmt_q[7];
      rdLsr_q <= rdTake && addr == 3'h5;
      if (wrTake && addr == 3'h3) fmt_q <= wrData;
      if (wrTake && addr == 3'h4) mc_q <= wrData;
      if (wrTake && addr == 3'h1 && !fmt_q[7]) ie_q <= wrData;
    end
  end
  a_break_low: assert property (
    fmt_q[6] && !mc_q[4] && $stable(fmt_q) && $stable(mc_q) |-> !serialOut)
    else $error("serial output not low during break");
  a_ready_pins: assert property (
    !mc_q[4] && $stable(mc_q) |-> termReady_n == !mc_q[0] && reqToSend_n == !mc_q[1])
    else $error("ready pins do not follow modem control");
  a_irq_drive: assert property (
    !mc_q[4] && $stable(mc_q) |-> irqOe_n == !mc_q[3])
    else $error("interrupt drive enable wrong");
  a_loop_park: assert property (
    mc_q[4] && $stable(mc_q) |-> serialOut && termReady_n && reqToSend_n && irqOe_n)
    else $error("pins not parked in loopback");
  a_soft_reset: assert property (
    !mc_q[4] && $stable(mc_q) && $stable(ie_q) |-> rstOut == (ie_q[5] && mc_q[2]))
    else $error("buffered reset output wrong");
  a_status_code: assert property (
    rdIsr_q |-> (!rdData[0] || rdData[3:1] == 3'h0) && rdData[7] == rdData[6])
    else $error("interrupt status inconsistent");
  a_enh_gate: assert property (
    rdIsr_q && !ie_q[5] && $stable(ie_q) |-> rdData[5:4] == 2'b00)
    else $error("ready flags shown without enhanced mode");
  a_tx_empty: assert property (
    rdLsr_q |-> !rdData[6] || rdData[5])
    else $error("transmitter empty without holding empty");
endmodule
bind uart_line_modem_status_regs uart_regs_checker chk_i (.clk_sys(clk_sys), .resetn(resetn),
  .addr(addr), .chipSel_n(chipSel_n), .rdStb_n(rdStb_n), .wrStb_n(wrStb_n), .wrData(wrData),
  .rdData(rdData), .serialOut(serialOut), .termReady_n(termReady_n),
  .reqToSend_n(reqToSend_n), .irqOe_n(irqOe_n), .rstOut(rstOut));

// *** dv/uart_line_partner.sv ***
`timescale 1ns/1ps
// far end of the cable: echoes the line and samples each frame
module uart_line_partner (
  input  wire logic        clk_sys,
  input  wire logic        txLine,
  input  wire logic        holdLow,
  output      logic        rxLine,
  output      logic [11:0] frame
);
  int cnt = 0;
  // echo, or a line held low to send a break
  assign rxLine = holdLow ? 1'b0 : txLine;
  // start plus eleven bits sampled at their centres, 16 cycles each
  always @(posedge clk_sys) begin
    if (cnt == 0 && !txLine) cnt <= 1;
    else if (cnt != 0) begin
      cnt <= (cnt == 192) ? 0 : cnt + 1;
      if (cnt % 16 == 8) frame <= {txLine, frame[11:1]};
    end
  end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys = 0, resetn = 0, chipSel_n = 1, rdStb_n = 1, wrStb_n = 1, holdLow = 0;
  logic [2:0]  addr = 0;
  logic [7:0]  wrData = 0, rdData, got;
  logic [3:0]  modemIn_n = 4'hF;
  logic        rdDataOe_n, serialIn, serialOut, termReady_n, reqToSend_n, irqOut, irqOe_n;
  logic        rstOut;
  logic [11:0] frame;
  logic [7:0]  fmts [7] = '{8'h00, 8'h05, 8'h0A, 8'h1F, 8'h2B, 8'h3B, 8'h04};
  int          err_total = 0, tests_run = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  uart_line_modem_status_regs uut (.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
    .chipSel_n(chipSel_n), .rdStb_n(rdStb_n), .wrStb_n(wrStb_n), .wrData(wrData),
    .rdData(rdData), .rdDataOe_n(rdDataOe_n), .serialIn(serialIn), .serialOut(serialOut),
    .clrToSend_n(modemIn_n[0]), .dataSetReady_n(modemIn_n[1]),
    .bellIndicateIn_n(modemIn_n[2]), .carrierDetectIn_n(modemIn_n[3]),
    .termReady_n(termReady_n), .reqToSend_n(reqToSend_n), .irqOut(irqOut),
    .irqOe_n(irqOe_n), .rstOut(rstOut));
  uart_line_partner far (.clk_sys(clk_sys), .txLine(serialOut), .holdLow(holdLow),
    .rxLine(serialIn), .frame(frame));
  // expected wire frame: start, data lsb first, parity, then ones
  function automatic logic [11:0] frm(input logic [7:0] f, input logic [7:0] d);
    logic [11:0] v;
    int          w;
    w = 5 + f[1:0];
    v = 12'hFFE;
    for (int i = 0; i < w; i++) v[1+i] = d[i];
    if (f[3]) v[1+w] = f[5] ? !f[4] : (^(d & ((8'h01 << w) - 1)) ^ !f[4]);
    return v;
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one host access: strobe low for one edge, then released
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    chipSel_n = 0; wrStb_n = 0; addr = a; wrData = d;
    @(negedge clk_sys);
    chipSel_n = 1; wrStb_n = 1;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge clk_sys);
    chipSel_n = 0; rdStb_n = 0; addr = a;
    @(negedge clk_sys);
    got = rdData;
    // data bus must be driven while the strobe is still held
    chk({rdDataOe_n, got & m}, {1'b0, e});
    chipSel_n = 1; rdStb_n = 1;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    resetn = 1;
    rc(2, 8'hFF, 8'h01);
    rc(5, 8'hFF, 8'h60);
    rc(3, 8'hFF, 8'h00);
    // divisor and feature storage only visible with the latch bit set
    wr(3, 8'h80);
    wr(0, 8'h01);
    wr(2, 8'h5A);
    rc(0, 8'hFF, 8'h01);
    rc(2, 8'hFF, 8'h5A);
    wr(3, 8'h00);
    chk({serialOut, termReady_n, reqToSend_n, irqOe_n, rstOut, irqOut}, 6'h3C);
    wr(4, 8'h0B);
    @(negedge clk_sys);
    chk({termReady_n, reqToSend_n, irqOe_n}, 3'h0);
    rc(4, 8'hFF, 8'h0B);
    wr(1, 8'h20);
    wr(4, 8'h04);
    @(negedge clk_sys);
    chk(rstOut, 1'b1);
    wr(1, 8'h00);
    @(negedge clk_sys);
    chk(rstOut, 1'b0);
    wr(3, 8'h40);
    repeat (3) @(negedge clk_sys);
    chk(serialOut, 1'b0);
    wr(3, 8'h00);
    // let the far end finish the frame window opened by the break
    repeat (200) @(negedge clk_sys);
    chk(serialOut, 1'b1);
    wr(2, 8'h01);
    wr(1, 8'h21);
    // each line format, echoed back through the cable
    foreach (fmts[i]) begin
      wr(3, fmts[i]);
      wr(0, 8'hA7);
      repeat (260) @(negedge clk_sys);
      chk(frame, frm(fmts[i], 8'hA7));
      chk(irqOut, 1'b1);
      rc(2, 8'hFF, 8'hF4);
      rc(5, 8'hFF, 8'h61);
      rc(0, 8'hFF, 8'hA7 & ((8'h01 << (5 + fmts[i][1:0])) - 1));
    end
    // fill the transmit side until it refuses, overrun the receiver
    wr(3, 8'h03);
    for (int i = 0; i < 18; i++) wr(0, 8'(i));
    rc(2, 8'h10, 8'h00);
    repeat (3000) @(negedge clk_sys);
    rc(5, 8'hFF, 8'h63);
    rc(2, 8'hF1, 8'hF0);
    for (int i = 0; i < 16; i++) rc(0, 8'hFF, 8'(i));
    rc(5, 8'h01, 8'h00);
    holdLow = 1;
    repeat (400) @(negedge clk_sys);
    holdLow = 0;
    repeat (100) @(negedge clk_sys);
    rc(5, 8'h11, 8'h11);
    rc(0, 8'hFF, 8'h00);
    rc(5, 8'h01, 8'h00);
    chk(irqOut, 1'b0);
    wr(4, 8'h1C);
    rc(6, 8'hF0, 8'hC0);
    wr(0, 8'h3C);
    repeat (260) @(negedge clk_sys);
    rc(0, 8'hFF, 8'h3C);
    wr(1, 8'h20);
    wr(4, 8'h80);
    wr(0, 8'h55);
    repeat (300) @(negedge clk_sys);
    rc(5, 8'h40, 8'h00);
    wr(4, 8'h00);
    repeat (300) @(negedge clk_sys);
    rc(5, 8'h40, 8'h40);
    give_verdict();
  end
endmodule
